/* File: sis_status.sv */
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
// supply and reset-cause status register with auxiliary detector interrupt
module sis_status
  import sis_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // auxiliary voltage detector output, asynchronous
  input wire logic i_aux_voltage_detector,
  // option byte: low-voltage detector present and enabled
  input wire logic i_lv_detect_enabled,
  // reset causes, one-cycle pulses from the reset controller
  input wire logic i_lv_reset_event,
  input wire logic i_watchdog_reset_event,
  input wire logic i_pin_reset_event,
  // cpu interrupt logic
  input wire logic i_halt_mode,
  input wire logic i_aux_irq_ack,
  output logic o_aux_irq_req,
  output logic [3:0] o_aux_irq_vector,
  output logic o_aux_irq_halt_wake
);

  // synchronised detector level and its change pulse
  sis_sync_if aux_sync ();

  // detector path through the synchroniser before any logic
  sis_edge_sync u_aux_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async_in(i_aux_voltage_detector),
    .o_sync(aux_sync.sync_side)
  );

  // state
  logic aux_ie_reg; // interrupt enable, software controlled
  logic aux_ie_next;
  logic aux_flag_reg; // detector level as seen by software
  logic aux_flag_next;
  logic lv_rst_reg; // last reset came from low-voltage detector
  logic lv_rst_next;
  logic wdg_rst_reg; // last reset came from watchdog
  logic wdg_rst_next;
  logic pend_reg; // pending auxiliary detector interrupt
  logic pend_next;
  logic req_reg; // request presented to the cpu
  logic req_next;
  logic [31:0] prdata_reg; // read data to the bus
  logic [31:0] prdata_next;
  logic pready_reg; // access phase answer
  logic pslverr_reg; // error answer on unmapped address
  logic [3:0] vector_reg; // vector slot shown to the interrupt logic
  logic halt_wake_reg; // whether the request may end halt

  // bus decoding
  wire addr_hit = (i_paddr == SIS_STATUS_ADDR[ADDR_W-1:0]);
  wire setup_phase = i_psel & ~i_penable;
  wire access_done = i_psel & i_penable & pready_reg;
  // only the low byte lane holds register bits
  wire wr_strobe = access_done & i_pwrite & addr_hit & i_pstrb[0];
  wire [7:0] wr_byte = i_pwdata[7:0];

  // any device reset returns the software controls to reset state
  wire dev_reset = i_lv_reset_event | i_watchdog_reset_event | i_pin_reset_event;

  // write-zero clears of the two reset-cause flags
  wire lv_sw_clear = wr_strobe & ~wr_byte[SIS_BIT_LV_RST];
  wire wdg_sw_clear = wr_strobe & ~wr_byte[SIS_BIT_WDG_RST];

  // with the detector disabled the flag has no meaning; keep it at zero
  wire lv_rst_visible = lv_rst_reg & i_lv_detect_enabled;

  // register image as software sees it; reserved bits read zero
  wire [7:0] status_image = {
    1'b0,
    aux_ie_reg,
    aux_flag_reg,
    lv_rst_visible,
    3'b000,
    wdg_rst_reg
  };

  // interrupt enable: software bit, cleared by every device reset
  always_comb begin
    aux_ie_next = aux_ie_reg;
    if (dev_reset) begin
      aux_ie_next = SIS_STATUS_RESET[SIS_BIT_AUX_IE];
    end else if (wr_strobe) begin
      aux_ie_next = wr_byte[SIS_BIT_AUX_IE];
    end
  end

  // detector flag follows hardware only; writes never reach it
  always_comb begin
    aux_flag_next = aux_sync.level;
  end

  // low-voltage reset flag: set beats a simultaneous software clear
  always_comb begin
    lv_rst_next = lv_rst_reg;
    if (i_lv_reset_event && i_lv_detect_enabled) begin
      lv_rst_next = 1'b1;
    end else if (i_pin_reset_event) begin
      lv_rst_next = 1'b0;
    end else if (lv_sw_clear) begin
      lv_rst_next = 1'b0;
    end
  end

  // watchdog reset flag: low-voltage reset wins so the cpu starts clean
  always_comb begin
    wdg_rst_next = wdg_rst_reg;
    if (i_lv_reset_event) begin
      wdg_rst_next = 1'b0;
    end else if (i_watchdog_reset_event) begin
      wdg_rst_next = 1'b1;
    end else if (i_pin_reset_event) begin
      wdg_rst_next = 1'b0;
    end else if (wdg_sw_clear) begin
      wdg_rst_next = 1'b0;
    end
  end

  // pending latch: a toggle in the acknowledge cycle is kept, not lost
  always_comb begin
    pend_next = pend_reg;
    if (dev_reset) begin
      pend_next = 1'b0;
    end else if (aux_sync.toggled && aux_ie_reg) begin
      pend_next = 1'b1;
    end else if (i_aux_irq_ack) begin
      pend_next = 1'b0;
    end
  end

  // request is withheld in halt modes, this source cannot wake the core
  always_comb begin
    req_next = pend_next & ~i_halt_mode;
  end

  // read data captured in the setup cycle, valid in the access phase
  always_comb begin
    prdata_next = prdata_reg;
    if (setup_phase) begin
      prdata_next = addr_hit ? {24'h00_0000, status_image} : SIS_RDATA_NONE;
    end
  end

  // status and control flops; reset values give 0x00 on power-up
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      aux_ie_reg <= SIS_STATUS_RESET[SIS_BIT_AUX_IE];
      aux_flag_reg <= SIS_STATUS_RESET[SIS_BIT_AUX_FLAG];
      lv_rst_reg <= SIS_STATUS_RESET[SIS_BIT_LV_RST];
      wdg_rst_reg <= SIS_STATUS_RESET[SIS_BIT_WDG_RST];
      pend_reg <= 1'b0;
      req_reg <= 1'b0;
    end else begin
      aux_ie_reg <= aux_ie_next;
      aux_flag_reg <= aux_flag_next;
      lv_rst_reg <= lv_rst_next;
      wdg_rst_reg <= wdg_rst_next;
      pend_reg <= pend_next;
      req_reg <= req_next;
    end
  end

  // apb answer: ready one cycle after setup, so every transfer has one
  // access cycle; costs no wait state and keeps every output registered
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      prdata_reg <= SIS_RDATA_NONE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase & ~addr_hit;
    end
  end

  // fixed interrupt attributes, held in flops to keep outputs registered
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      vector_reg <= 4'h0;
      halt_wake_reg <= 1'b0;
    end else begin
      vector_reg <= SIS_AUX_VECTOR;
      halt_wake_reg <= SIS_AUX_HALT_WAKE;
    end
  end

  // reserved bits of a write are simply dropped, so a careless
  // nonzero write does no harm beyond reading back as zero

  // outputs
  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_aux_irq_req = req_reg;
  assign o_aux_irq_vector = vector_reg;
  assign o_aux_irq_halt_wake = halt_wake_reg;

endmodule // sis_status

/* File: sis_pkg.sv */
package sis_pkg;

  // register index as printed, byte address is four times it
  localparam logic [11:0] SIS_STATUS_INDEX = 12'h02b;
  localparam logic [11:0] SIS_STATUS_ADDR = 12'(SIS_STATUS_INDEX * 4);

  // field positions of supply_and_reset_cause_status
  localparam int SIS_BIT_WDG_RST = 0;
  localparam int SIS_BIT_LV_RST = 4;
  localparam int SIS_BIT_AUX_FLAG = 5;
  localparam int SIS_BIT_AUX_IE = 6;

  // reset value of the whole register
  localparam logic [7:0] SIS_STATUS_RESET = 8'h00;

  // interrupt vector slot of the auxiliary detector
  localparam logic [3:0] SIS_AUX_VECTOR = 4'hb;

  // auxiliary detector interrupt may not leave halt modes
  localparam logic SIS_AUX_HALT_WAKE = 1'b0;

  // read data on an unmapped address
  localparam logic [31:0] SIS_RDATA_NONE = 32'h0000_0000;

endpackage

/* File: sis_sync_if.sv */
`timescale 1ns/1ps
// carries the detector level between the synchroniser and the register logic
interface sis_sync_if;
  logic level; // synchronised detector level
  logic toggled; // one-cycle pulse on any change of level

  // producer side: the synchroniser
  modport sync_side (
    output level,
    output toggled
  );

  // consumer side: the status register logic
  modport reg_side (
    input level,
    input toggled
  );
endinterface

/* File: sis_edge_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser with a change detector behind it
module sis_edge_sync (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_async_in,
  sis_sync_if.sync_side o_sync
);

  logic meta_reg; // first stage, read only by the second stage
  logic stable_reg; // second stage, safe to use
  logic last_reg; // previous settled value for change detection
  logic toggled_reg; // registered change pulse
  wire changed = stable_reg ^ last_reg; // either direction counts

  // sampling chain; reset level matches the reset value of the flag
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b0;
      stable_reg <= 1'b0;
      last_reg <= 1'b0;
      toggled_reg <= 1'b0;
    end else begin
      meta_reg <= i_async_in;
      stable_reg <= meta_reg;
      last_reg <= stable_reg;
      toggled_reg <= changed;
    end
  end

  // level is aligned with the pulse so both describe the same change
  assign o_sync.level = last_reg;
  assign o_sync.toggled = toggled_reg;

endmodule // sis_edge_sync

/* File: sis_status_monitor.sv */
`timescale 1ns/1ps
// watches the bus answer and the interrupt request at the top ports
module sis_status_monitor
  import sis_pkg::*;
#(parameter int ADDR_W = 12) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_aux_voltage_detector,
  input wire logic i_halt_mode,
  input wire logic i_aux_irq_ack,
  input wire logic o_aux_irq_req,
  input wire logic [3:0] o_aux_irq_vector,
  input wire logic o_aux_irq_halt_wake
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // setup cycle of a transfer
  sequence setup_s; i_psel && !i_penable; endsequence
  // ack with no detector change in flight, so a fresh toggle cannot re-arm
  sequence quiet_ack_s; $stable(i_aux_voltage_detector)[*5] ##0 i_aux_irq_ack; endsequence
  wait_free_a: assert property (setup_s |=> o_pready) else $error("pready late");
  pready_pulse_a: assert property (o_pready |=> !o_pready) else $error("pready too long");
  slverr_map_a: assert property (o_pready |-> o_pslverr == (i_paddr != SIS_STATUS_ADDR))
    else $error("pslverr wrong for address");
  reserved_zero_a: assert property (o_pready |-> (o_prdata & 32'hffff_ff8e) == 32'h0)
    else $error("reserved bits read nonzero");
  unmapped_zero_a: assert property (o_pready && o_pslverr |-> o_prdata == SIS_RDATA_NONE)
    else $error("unmapped read not zero");
  ack_clear_a: assert property (quiet_ack_s |=> ##1 !o_aux_irq_req)
    else $error("request survived ack");
  halt_mask_a: assert property (i_halt_mode |=> !o_aux_irq_req)
    else $error("request shown in halt");
  vector_slot_a: assert property (i_rst_n[*4] |-> o_aux_irq_vector == SIS_AUX_VECTOR)
    else $error("wrong vector slot");
  no_halt_wake_a: assert property (o_aux_irq_halt_wake == SIS_AUX_HALT_WAKE)
    else $error("halt wake raised");
  cover property (o_aux_irq_req && i_aux_irq_ack);
endmodule // sis_status_monitor

/* File: sis_cpu_model.sv */
`timescale 1ns/1ps
// cpu interrupt logic: enters the service routine some cycles after a request
module sis_cpu_model (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_irq_req,
  input wire logic i_slow,
  output logic o_ack
);
  logic [2:0] wait_reg; // cycles the request has been seen
  wire logic [2:0] lat = i_slow ? 3'h4 : 3'h1; // answer promptly or slowly
  // one ack pulse, then a hold-off while the request drains away
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wait_reg <= 3'h0;
      o_ack <= 1'b0;
    end else begin
      o_ack <= i_irq_req && wait_reg == lat;
      wait_reg <= (!i_irq_req || wait_reg == lat + 3'h2) ? 3'h0 : wait_reg + 3'h1;
    end
  end
endmodule // sis_cpu_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import sis_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, det, lv_en;
  logic lv_ev, wdg_ev, pin_ev, halt, ack, req, wake, slow, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, vec;
  int n_fail = 0;
  int check_count = 0;
  typedef struct {logic w; logic [11:0] a; logic [7:0] d; logic [3:0] s; logic [7:0] x;
    logic e;} sis_row_s;
  // read-only and write-zero bits ignore ones; reserved bits are always written as zero
  sis_row_s rows [7] = '{'{1'h1, SIS_STATUS_ADDR, 8'h71, 4'h1, 8'h0, 1'h0},
    '{1'h0, SIS_STATUS_ADDR, 8'h0, 4'h0, 8'h40, 1'h0},
    '{1'h1, SIS_STATUS_ADDR, 8'h0, 4'h0, 8'h0, 1'h0},
    '{1'h0, SIS_STATUS_ADDR, 8'h0, 4'h0, 8'h40, 1'h0},
    '{1'h0, 12'h0b0, 8'h0, 4'h0, 8'h0, 1'h1},
    '{1'h1, 12'h0b0, 8'h0, 4'h1, 8'h0, 1'h1},
    '{1'h0, SIS_STATUS_ADDR, 8'h0, 4'h0, 8'h40, 1'h0}};
  sis_status #(.ADDR_W(12)) sis_status_inst (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_aux_voltage_detector(det),
    .i_lv_detect_enabled(lv_en), .i_lv_reset_event(lv_ev), .i_watchdog_reset_event(wdg_ev),
    .i_pin_reset_event(pin_ev), .i_halt_mode(halt), .i_aux_irq_ack(ack), .o_aux_irq_req(req),
    .o_aux_irq_vector(vec), .o_aux_irq_halt_wake(wake));
  sis_cpu_model sis_cpu_model_inst (.i_clock(clk), .i_rst_n(rst_n), .i_irq_req(req),
    .i_slow(slow), .o_ack(ack));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic [3:0] s);
    int n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'h2, w, a, 24'h0, d, s};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (!pready && n < 20) begin
      n++;
      @(posedge clk);
    end
    // a wait that runs out is a failure, not a silent skip
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic rdx(input logic [7:0] x);
    apb(1'h0, SIS_STATUS_ADDR, 8'h0, 4'h0);
    chk("status", rd, {24'h0, x});
  endtask
  // bounded wait for the request level
  task automatic wait_req(input logic v);
    int n = 0;
    while (req !== v && n < 40) begin
      n++;
      @(posedge clk);
    end
    chk("irq_req", 32'(req), 32'(v));
  endtask
  // one-cycle reset-cause pulse: lv, watchdog, pin
  task automatic ev(input logic [2:0] e);
    @(posedge clk);
    {lv_ev, wdg_ev, pin_ev} <= e;
    @(posedge clk);
    {lv_ev, wdg_ev, pin_ev} <= 3'h0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb, det, lv_ev, wdg_ev} = '0;
    {pin_ev, halt, slow, lv_en} = 4'h1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdx(SIS_STATUS_RESET[7:0]);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
      chk("pslverr", 32'(er), 32'(rows[i].e));
      if (!rows[i].w) chk("prdata", rd, {24'h0, rows[i].x});
    end
    det <= 1'b1;
    wait_req(1'h1);
    wait_req(1'h0);
    rdx(8'h60);
    halt <= 1'b1;
    det <= 1'b0;
    repeat (10) @(posedge clk);
    chk("irq_req", 32'(req), 32'h0);
    {halt, slow} <= 2'h1;
    wait_req(1'h1);
    wait_req(1'h0);
    ev(3'h2);
    rdx(8'h01);
    ev(3'h4);
    rdx(8'h10);
    ev(3'h2);
    ev(3'h1);
    rdx(8'h00);
    lv_en <= 1'b0;
    ev(3'h4);
    rdx(8'h00);
    lv_en <= 1'b1;
    ev(3'h4);
    ev(3'h2);
    apb(1'h1, SIS_STATUS_ADDR, 8'h01, 4'h1);
    rdx(8'h01);
    apb(1'h1, SIS_STATUS_ADDR, 8'h00, 4'h1);
    rdx(8'h00);
    // mid-run port reset: enable set first so the reset has something to clear
    apb(1'h1, SIS_STATUS_ADDR, 8'h40, 4'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pready", 32'(pready), 32'h0);
    chk("irq_vector", 32'(vec), 32'h0);
    chk("irq_req", 32'(req), 32'h0);
    rst_n <= 1'b1;
    rdx(8'h00);
    // fixed interrupt attributes are settled by now
    chk("irq_vector", 32'(vec), 32'(SIS_AUX_VECTOR));
    chk("irq_halt_wake", 32'(wake), 32'(SIS_AUX_HALT_WAKE));
    report_and_stop;
  end
  // hang guard, far beyond the hundred-odd cycles the tests take
  initial begin
    #(25 * 5000);
    n_fail++;
    report_and_stop;
  end
endmodule // tb_top
bind sis_status sis_status_monitor #(.ADDR_W(ADDR_W)) sis_status_monitor_inst (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_aux_voltage_detector(i_aux_voltage_detector), .i_halt_mode(i_halt_mode),
  .i_aux_irq_ack(i_aux_irq_ack), .o_aux_irq_req(o_aux_irq_req),
  .o_aux_irq_vector(o_aux_irq_vector), .o_aux_irq_halt_wake(o_aux_irq_halt_wake));
